//--- logic/edsc_cfg.svh
// Purpose: Constants for the end device sleep controller.
// Assumes: 125 MHz clock.
// Notes:   Register offsets are byte addresses on an APB slave.
`ifndef EDSC_CFG_SVH
`define EDSC_CFG_SVH
`define EDSC_CLK_HZ 125000000
`define EDSC_TICK_MS 10
`define EDSC_TICK_CYC ((`EDSC_CLK_HZ / 1000) * `EDSC_TICK_MS)
`define EDSC_POLL_MS 100
`define EDSC_POLL_TICKS (`EDSC_POLL_MS / `EDSC_TICK_MS)
`define EDSC_MODE_PIN 8'h01
`define EDSC_MODE_CYC_TIMED 8'h04
`define EDSC_MODE_CYC_PIN 8'h05
`define EDSC_SP_MIN 16'h0020
`define EDSC_SP_MAX 16'h0af0
`define EDSC_SN_MIN 16'h0001
`define EDSC_OPT_FULL_HOLD 1
`define EDSC_OPT_EXTENDED 2
`define EDSC_OFF_MODE 12'h000
`define EDSC_OFF_PERIOD 12'h004
`define EDSC_OFF_MULT 12'h008
`define EDSC_OFF_OPTIONS 12'h00c
`define EDSC_OFF_HOLD 12'h010
`define EDSC_OFF_CTRL 12'h014
`define EDSC_OFF_STATUS 12'h018
`define EDSC_OFF_CHMASK 12'h01c
`define EDSC_RST_MODE 8'h00
`define EDSC_RST_PERIOD 16'h0020
`define EDSC_RST_MULT 16'h0001
`define EDSC_RST_HOLD 16'h01f4
`define EDSC_RST_CHMASK 16'hffff
`endif

//--- logic/edsc_pkg.sv
// Purpose: Types for the end device sleep controller.
// Assumes: Nothing.
// Notes:   State encoding is the enum order, 0 to 5, as read in the status word.
package edsc_pkg;
	typedef enum logic [2:0] {
		EDSC_AWAKE_IDLE,
		EDSC_POLL_WAIT,
		EDSC_RX_DATA,
		EDSC_SCAN,
		EDSC_DRAIN,
		EDSC_SLEEP
	} edsc_state_e;
endpackage

//--- logic/edsc_sleep_ctrl.sv
// Purpose: Sleep and wake controller of a battery powered end device.
// Assumes: All inputs synchronous to clk; radio and serial report by pulses.
// Notes:   Registers on APB, one aligned word each, low bits used.
//
// Functional notes
// - While awake, poll the parent every 100 ms.
// - After a poll, keep the receiver on until the acknowledgment.
// - Pending data keeps the receiver on; otherwise receiver off until next poll.
// - Entering sleep drives the awake indicator low.
// - With flow control on, entering sleep drives CTS high.
// - Waking drives awake indicator high and, with flow control, CTS low.
// - Serial and radio data are ignored while sleeping.
// - Unjoined on wake, scan every channel in the scan channel mask.
// - Sleep mode setting 1 selects pin sleep.
// - Raised sleep request sleeps after transmit, receive or scan completes.
// - Lowered sleep request wakes the device in pin sleep.
// - Sleep mode setting 4 or 5 selects cyclic sleep.
// - Mode 5 wakes on period expiry or request line falling edge.
// - Mode 4 wakes only on period expiry.
// - After cyclic poll stay awake on parent or serial data, else sleep.
// - Data arrival starts or restarts the configurable wake hold timer.
// - Cyclic sleep resumes on hold timer expiry or immediate sleep command.
// - Sleep period accepted from 0x20 to 0xaf0, in 10 ms units.
// - Period multiplier accepted from 1 to 0xffff.
// - Options bit 0x02 forces full hold; bit 0x04 enables extended sleep (the wake still comes after one sleep period).
// - In cyclic sleep, multiplier above one raises indicator only on radio data or count.
`include "edsc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module edsc_sleep_ctrl
	import edsc_pkg::*;
#(
	parameter int TICK_CYCLES = `EDSC_TICK_CYC,
	parameter int POLL_TICKS = `EDSC_POLL_TICKS
) (
	// Clock, reset and clock enable.
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Host side pins.
	input wire logic sleepRequestLine,
	input wire logic flowControlPinConfig,
	output logic awakeIndicator,
	output logic ctsN,
	// Radio and serial activity.
	input wire logic joined,
	input wire logic txBusy,
	input wire logic serialRxPulse,
	input wire logic radioRxPulse,
	input wire logic pollAck,
	input wire logic ackPending,
	input wire logic rxDone,
	input wire logic scanDone,
	output logic pollRequest,
	output logic rxEnable,
	output logic scanStart,
	output logic [15:0] scanChannelMask,
	output logic sleeping
);

	// ------------------------------------------------------------------
	// Register file.
	// ------------------------------------------------------------------
	logic [7:0] sleepModeSelect_ff;
	logic [15:0] sleepPeriodSetting_ff;
	logic [15:0] periodMultiplier_ff;
	logic [7:0] sleepOptions_ff;
	logic [15:0] wakeHoldTimer_ff;
	logic [15:0] chMask_ff;
	logic sleepNow_ff;
	edsc_state_e state_ff;
	logic [31:0] rdData;
	logic rdHit;
	logic wrAcc;

	// Clamp a requested value into the accepted range.
	function automatic logic [15:0] clampRange(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	assign pready = 1'b1;
	assign wrAcc = psel && penable && pwrite;
	assign pslverr = psel && penable && !rdHit;

	// Software writes; out of range periods are clamped, not rejected.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sleepModeSelect_ff <= `EDSC_RST_MODE;
			sleepPeriodSetting_ff <= `EDSC_RST_PERIOD;
			periodMultiplier_ff <= `EDSC_RST_MULT;
			sleepOptions_ff <= 8'h00;
			wakeHoldTimer_ff <= `EDSC_RST_HOLD;
			chMask_ff <= `EDSC_RST_CHMASK;
		end else if (clkEn && wrAcc) begin
			unique case (paddr)
				`EDSC_OFF_MODE: sleepModeSelect_ff <= pwdata[7:0];
				`EDSC_OFF_PERIOD: sleepPeriodSetting_ff <= clampRange(pwdata[15:0],
					`EDSC_SP_MIN, `EDSC_SP_MAX);
				`EDSC_OFF_MULT: periodMultiplier_ff <= clampRange(pwdata[15:0],
					`EDSC_SN_MIN, 16'hffff);
				`EDSC_OFF_OPTIONS: sleepOptions_ff <= pwdata[7:0];
				`EDSC_OFF_HOLD: wakeHoldTimer_ff <= pwdata[15:0];
				`EDSC_OFF_CHMASK: chMask_ff <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// Immediate sleep command: a write of bit 0 to the control word.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sleepNow_ff <= 1'b0;
		end else if (clkEn) begin
			sleepNow_ff <= wrAcc && paddr == `EDSC_OFF_CTRL && pwdata[0];
		end
	end

	// Read decode.
	always_comb begin
		rdHit = 1'b1;
		rdData = 32'h0000_0000;
		unique case (paddr)
			`EDSC_OFF_MODE: rdData = {24'h00_0000, sleepModeSelect_ff};
			`EDSC_OFF_PERIOD: rdData = {16'h0000, sleepPeriodSetting_ff};
			`EDSC_OFF_MULT: rdData = {16'h0000, periodMultiplier_ff};
			`EDSC_OFF_OPTIONS: rdData = {24'h00_0000, sleepOptions_ff};
			`EDSC_OFF_HOLD: rdData = {16'h0000, wakeHoldTimer_ff};
			`EDSC_OFF_CTRL: rdData = 32'h0000_0000;
			`EDSC_OFF_STATUS: rdData = {26'h000_0000, awakeIndicator, rxEnable, sleeping,
				3'(state_ff)};
			`EDSC_OFF_CHMASK: rdData = {16'h0000, chMask_ff};
			default: rdHit = 1'b0;
		endcase
	end

	// Read data is registered so that it is stable in the access phase.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
		end else if (clkEn && psel && !penable && !pwrite) begin
			prdata <= rdData;
		end
	end

	// ------------------------------------------------------------------
	// Time base.
	// ------------------------------------------------------------------
	logic [23:0] tickCnt_ff;
	logic tick;
	assign tick = tickCnt_ff == 24'(TICK_CYCLES - 1);

	// Free running 10 ms tick for every timer below.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tickCnt_ff <= 24'h00_0000;
		end else if (clkEn) begin
			tickCnt_ff <= tick ? 24'h00_0000 : tickCnt_ff + 24'h00_0001;
		end
	end

	// ------------------------------------------------------------------
	// Mode decode and sleep sequencer.
	// ------------------------------------------------------------------
	logic pinMode;
	logic cyclicMode;
	logic reqPrev_ff;
	logic reqFall;
	logic [7:0] pollCnt_ff;
	logic [15:0] periodCnt_ff;
	logic [15:0] multCnt_ff;
	logic [15:0] holdCnt_ff;
	logic holdRun_ff;
	logic polledOnce_ff;
	logic periodDone;
	logic dataIn;
	logic wantSleep;
	logic pollDue;
	edsc_state_e nxt_state;

	assign pinMode = sleepModeSelect_ff == `EDSC_MODE_PIN;
	assign cyclicMode = sleepModeSelect_ff == `EDSC_MODE_CYC_TIMED
		|| sleepModeSelect_ff == `EDSC_MODE_CYC_PIN;
	assign reqFall = reqPrev_ff && !sleepRequestLine;
	assign sleeping = state_ff == EDSC_SLEEP;
	assign dataIn = !sleeping && (serialRxPulse || radioRxPulse);
	assign periodDone = tick && periodCnt_ff <= 16'h0001;
	assign pollDue = tick && pollCnt_ff >= 8'(POLL_TICKS - 1);

	// Pin sleep wants sleep on a high request line; cyclic sleep once the hold
	// timer is idle, unless the full hold option keeps it running.
	always_comb begin
		wantSleep = 1'b0;
		if (pinMode) begin
			wantSleep = sleepRequestLine;
		end else if (cyclicMode) begin
			wantSleep = sleepNow_ff || (!holdRun_ff && polledOnce_ff);
		end
	end

	// Sequencer: sleep is entered only from idle, so transfers finish first.
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			EDSC_AWAKE_IDLE: begin
				if (!joined) begin
					nxt_state = EDSC_SCAN;
				end else if (wantSleep && !txBusy) begin
					nxt_state = EDSC_SLEEP;
				end else if (pollDue) begin
					nxt_state = EDSC_POLL_WAIT;
				end
			end
			EDSC_POLL_WAIT: begin
				if (pollAck) begin
					nxt_state = ackPending ? EDSC_RX_DATA : EDSC_AWAKE_IDLE;
				end
			end
			EDSC_RX_DATA: if (rxDone) nxt_state = EDSC_AWAKE_IDLE;
			EDSC_SCAN: if (scanDone) nxt_state = EDSC_AWAKE_IDLE;
			EDSC_DRAIN: nxt_state = EDSC_AWAKE_IDLE;
			EDSC_SLEEP: begin
				if (pinMode && !sleepRequestLine) begin
					nxt_state = EDSC_DRAIN;
				end else if (cyclicMode && (periodDone
					|| (sleepModeSelect_ff == `EDSC_MODE_CYC_PIN && reqFall))) begin
					nxt_state = EDSC_DRAIN;
				end
			end
			default: nxt_state = EDSC_AWAKE_IDLE;
		endcase
	end

	// State register and request line history.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= EDSC_AWAKE_IDLE;
			reqPrev_ff <= 1'b0;
		end else if (clkEn) begin
			state_ff <= nxt_state;
			reqPrev_ff <= sleepRequestLine;
		end
	end

	// Poll interval; a wake forces a poll at the next tick by preloading the count.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pollCnt_ff <= 8'h00;
		end else if (clkEn) begin
			if (state_ff == EDSC_DRAIN) begin
				pollCnt_ff <= 8'(POLL_TICKS - 1);
			end else if (state_ff == EDSC_POLL_WAIT) begin
				pollCnt_ff <= 8'h00;
			end else if (tick && state_ff != EDSC_SLEEP && !pollDue) begin
				pollCnt_ff <= pollCnt_ff + 8'h01;
			end
		end
	end

	// Poll strobe and receiver gate.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pollRequest <= 1'b0;
			scanStart <= 1'b0;
		end else if (clkEn) begin
			pollRequest <= state_ff == EDSC_AWAKE_IDLE && nxt_state == EDSC_POLL_WAIT;
			scanStart <= state_ff == EDSC_AWAKE_IDLE && nxt_state == EDSC_SCAN;
		end
	end
	assign rxEnable = state_ff == EDSC_POLL_WAIT || state_ff == EDSC_RX_DATA;
	assign scanChannelMask = chMask_ff;

	// Sleep period and multiplier counters; the wake comes after one SP even with extended sleep.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			periodCnt_ff <= `EDSC_RST_PERIOD;
			multCnt_ff <= 16'h0000;
		end else if (clkEn) begin
			if (state_ff != EDSC_SLEEP) begin
				periodCnt_ff <= sleepPeriodSetting_ff;
				multCnt_ff <= sleepOptions_ff[`EDSC_OPT_EXTENDED] ? periodMultiplier_ff
					: 16'h0001;
			end else if (tick) begin
				if (periodCnt_ff > 16'h0001) begin
					periodCnt_ff <= periodCnt_ff - 16'h0001;
				end else if (multCnt_ff > 16'h0001) begin
					periodCnt_ff <= sleepPeriodSetting_ff;
					multCnt_ff <= multCnt_ff - 16'h0001;
				end
			end
		end
	end

	// Wake hold timer, restarted by every data arrival while awake.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			holdCnt_ff <= 16'h0000;
			holdRun_ff <= 1'b0;
		end else if (clkEn) begin
			if (sleeping || sleepNow_ff) begin
				holdRun_ff <= 1'b0;
			end else if (dataIn || (state_ff == EDSC_POLL_WAIT && pollAck && ackPending)
				|| (state_ff == EDSC_DRAIN && sleepOptions_ff[`EDSC_OPT_FULL_HOLD])) begin
				holdCnt_ff <= wakeHoldTimer_ff;
				holdRun_ff <= 1'b1;
			end else if (tick && holdRun_ff) begin
				if (holdCnt_ff <= 16'h0001) begin
					holdRun_ff <= 1'b0;
				end else begin
					holdCnt_ff <= holdCnt_ff - 16'h0001;
				end
			end
		end
	end

	// Unless commanded to sleep at once, a cyclic wake must see one acknowledged poll before it may sleep again;
	// without this the idle state would fall straight back to sleep unpolled.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			polledOnce_ff <= 1'b0;
		end else if (clkEn) begin
			if (sleeping) begin
				polledOnce_ff <= 1'b0;
			end else if (state_ff == EDSC_POLL_WAIT && pollAck) begin
				polledOnce_ff <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Host facing pins.
	// ------------------------------------------------------------------
	logic [15:0] wakeCnt_ff;

	// Wake cycle count for the multiplier gated indicator.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wakeCnt_ff <= 16'h0000;
		end else if (clkEn && state_ff == EDSC_SLEEP && nxt_state == EDSC_DRAIN) begin
			wakeCnt_ff <= (wakeCnt_ff + 16'h0001 >= periodMultiplier_ff) ? 16'h0000
				: wakeCnt_ff + 16'h0001;
		end
	end

	// Indicator and CTS follow sleep entry and wake; CTS idles low when unused.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			awakeIndicator <= 1'b1;
			ctsN <= 1'b0;
		end else if (clkEn) begin
			if (nxt_state == EDSC_SLEEP) begin
				awakeIndicator <= 1'b0;
				ctsN <= flowControlPinConfig;
			end else if (state_ff == EDSC_SLEEP) begin
				ctsN <= 1'b0;
				awakeIndicator <= !cyclicMode || periodMultiplier_ff == 16'h0001
					|| wakeCnt_ff + 16'h0001 >= periodMultiplier_ff;
			end else if (radioRxPulse) begin
				awakeIndicator <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

//--- verification/edsc_far_model.sv
// Purpose: Host and parent stand-in for the sleep controller.
// Assumes: The parent answers each poll three cycles later.
// Notes: ackPending toggles outside its pulse, so stale values never pass.
`timescale 1ns/10ps
`default_nettype none
module edsc_far_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Scenario controls.
	input wire logic reqLevel,
	input wire logic pending,
	// Device side.
	input wire logic pollRequest,
	input wire logic scanStart,
	output logic sleepRequestLine,
	output logic pollAck,
	output logic ackPending,
	output logic rxDone,
	output logic scanDone
);
	logic [2:0] pollDly_ff;
	logic [1:0] dataDly_ff;
	logic [3:0] scanDly_ff;
	// The host moves its request line just after an edge.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) sleepRequestLine <= 1'b0;
		else sleepRequestLine <= reqLevel;
	end
	// The parent acknowledges, sends any data, and ends each scan later.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pollDly_ff <= '0;
			dataDly_ff <= '0;
			scanDly_ff <= '0;
			ackPending <= 1'b0;
		end else begin
			pollDly_ff <= {pollDly_ff[1:0], pollRequest};
			dataDly_ff <= {dataDly_ff[0], pollDly_ff[2] & pending};
			scanDly_ff <= {scanDly_ff[2:0], scanStart};
			ackPending <= pollDly_ff[1] ? pending : ~ackPending;
		end
	end
	// Pulses come straight off the delay lines.
	assign pollAck = pollDly_ff[2];
	assign rxDone = dataDly_ff[1];
	assign scanDone = scanDly_ff[3];
endmodule
`default_nettype wire

//--- verification/edsc_sleep_monitor.sv
// Purpose: Port checker for the sleep controller.
// Assumes: clkEn high.
// Notes: The wake check assumes a period multiplier of one.
`timescale 1ns/10ps
`default_nettype none
module edsc_sleep_monitor #(
	parameter int TICK_CYCLES = 10,
	parameter int POLL_TICKS = 10
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Pins and link.
	input wire logic flowControlPinConfig,
	input wire logic awakeIndicator,
	input wire logic ctsN,
	input wire logic joined,
	input wire logic txBusy,
	input wire logic pollAck,
	input wire logic ackPending,
	input wire logic rxDone,
	input wire logic pollRequest,
	input wire logic rxEnable,
	input wire logic scanStart,
	input wire logic sleeping
);
	localparam int POLL_LIM = (POLL_TICKS + 2) * TICK_CYCLES + 8;
	localparam int SCAN_LIM = 2 * TICK_CYCLES + 8;
	logic [15:0] idleCnt_ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Awake cycles since the last poll; a lost poll shows as a count above POLL_LIM.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) idleCnt_ff <= '0;
		else if (pollRequest || sleeping || !joined) idleCnt_ff <= '0;
		else idleCnt_ff <= idleCnt_ff + 16'h0001;
	end
	sequence s_ackData; pollAck && ackPending && !rxDone; endsequence
	sequence s_woke; ##[0:2] awakeIndicator && (!ctsN || !flowControlPinConfig); endsequence
	property p_poll; idleCnt_ff <= POLL_LIM; endproperty
	property p_listen; pollRequest |=> rxEnable; endproperty
	property p_ackOff; pollAck && !ackPending |=> !rxEnable; endproperty
	property p_ackKeep; s_ackData |=> rxEnable; endproperty
	property p_ind; sleeping |-> !awakeIndicator; endproperty
	property p_cts; sleeping && flowControlPinConfig |-> ctsN; endproperty
	property p_wake; $fell(sleeping) |-> s_woke; endproperty
	property p_deaf; sleeping |-> !rxEnable && !pollRequest; endproperty
	property p_scan; $fell(sleeping) && !joined |-> ##[1:SCAN_LIM] scanStart; endproperty
	property p_busy; $rose(sleeping) |-> !$past(txBusy); endproperty
	a_poll: assert property (p_poll) else $error("poll late");
	a_listen: assert property (p_listen) else $error("deaf after poll");
	a_ackOff: assert property (p_ackOff) else $error("rx left on");
	a_ackKeep: assert property (p_ackKeep) else $error("rx dropped");
	a_ind: assert property (p_ind) else $error("indicator high asleep");
	a_cts: assert property (p_cts) else $error("cts low asleep");
	a_wake: assert property (p_wake) else $error("wake pins wrong");
	a_deaf: assert property (p_deaf) else $error("active asleep");
	a_scan: assert property (p_scan) else $error("no scan");
	a_busy: assert property (p_busy) else $error("slept while busy");
endmodule
`default_nettype wire

//--- verification/edsc_sleep_ctrl_tb_top.sv
// Purpose: Directed bench for the sleep controller.
// Assumes: A tick of ten cycles, so polls come every 100 cycles.
// Notes: Pin checks are taken at the falling edge; drives and APB reads at the rising edge.
`include "edsc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module edsc_sleep_ctrl_tb_top;
	localparam logic [11:0] ROF [5] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h01c};
	localparam logic [31:0] RST [5] = '{32'h0, 32'h20, 32'h1, 32'h1f4, 32'hffff};
	localparam logic [11:0] WOF [7] = '{12'h004, 12'h004, 12'h004, 12'h008, 12'h008,
		12'h00c, 12'h010};
	localparam logic [31:0] WIN [7] = '{32'h10, 32'hfff, 32'h20, 32'hffff, 32'h0, 32'h6, 32'h3};
	localparam logic [31:0] WEX [7] = '{32'h20, 32'haf0, 32'h20, 32'hffff, 32'h1, 32'h6, 32'h3};
	logic clk = 1'b0, resetn = 1'b0, clkEn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic flowControlPinConfig = 1'b1, joined = 1'b1, txBusy = 1'b0, reqLevel = 1'b0;
	logic serialRxPulse = 1'b0, radioRxPulse = 1'b0, pending = 1'b0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] scanChannelMask;
	logic pready, pslverr, awakeIndicator, ctsN, pollRequest, rxEnable, scanStart, sleeping;
	logic sleepRequestLine, pollAck, ackPending, rxDone, scanDone;
	int miscompares = 0, n_checks = 0, polls;
	// Free running clock.
	always #4 clk = ~clk;
	edsc_sleep_ctrl #(.TICK_CYCLES(10), .POLL_TICKS(10)) dut_u (.clk(clk), .resetn(resetn),
		.clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleepRequestLine(sleepRequestLine), .flowControlPinConfig(flowControlPinConfig),
		.awakeIndicator(awakeIndicator), .ctsN(ctsN), .joined(joined), .txBusy(txBusy),
		.serialRxPulse(serialRxPulse), .radioRxPulse(radioRxPulse), .pollAck(pollAck),
		.ackPending(ackPending), .rxDone(rxDone), .scanDone(scanDone),
		.pollRequest(pollRequest), .rxEnable(rxEnable), .scanStart(scanStart),
		.scanChannelMask(scanChannelMask), .sleeping(sleeping));
	edsc_far_model far_u (.clk(clk), .resetn(resetn), .reqLevel(reqLevel), .pending(pending),
		.pollRequest(pollRequest), .scanStart(scanStart), .sleepRequestLine(sleepRequestLine),
		.pollAck(pollAck), .ackPending(ackPending), .rxDone(rxDone), .scanDone(scanDone));
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task timeout;
		miscompares++;
		$display("mismatch at %0t: wait limit reached", $time);
		complete_run;
	endtask
	task chkWord(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task chkBit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	// One APB transfer; the request holds until pready is seen high.
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) timeout;
	endtask
	task waitSleep(input logic v, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sleeping !== v && n < lim);
		if (sleeping !== v) timeout;
	endtask
	task pulse(input int which);
		@(posedge clk);
		if (which == 0) serialRxPulse <= 1'b1;
		else radioRxPulse <= 1'b1;
		@(posedge clk);
		serialRxPulse <= 1'b0;
		radioRxPulse <= 1'b0;
		repeat (20) @(negedge clk);
	endtask
	// Main sequence.
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ROF[i], 32'h0);
			chkWord(rd, RST[i]);
		end
		chkWord({16'h0000, scanChannelMask}, 32'h0000_ffff);
		apb(1'b0, 12'h040, 32'h0);
		chkBit(er, 1'b1);
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, WOF[i], WIN[i]);
			apb(1'b0, WOF[i], 32'h0);
			chkWord(rd, WEX[i]);
		end
		txBusy <= 1'b1;
		reqLevel <= 1'b1;
		apb(1'b1, `EDSC_OFF_MODE, 32'h1);
		repeat (40) @(negedge clk);
		chkBit(sleeping, 1'b0);
		@(posedge clk);
		txBusy <= 1'b0;
		waitSleep(1'b1, 200);
		chkBit(awakeIndicator, 1'b0);
		chkBit(ctsN, 1'b1);
		pulse(1);
		chkBit(sleeping, 1'b1);
		@(posedge clk);
		joined <= 1'b0;
		reqLevel <= 1'b0;
		waitSleep(1'b0, 20);
		repeat (3) @(negedge clk);
		chkBit(awakeIndicator, 1'b1);
		chkBit(ctsN, 1'b0);
		@(posedge clk);
		joined <= 1'b1;
		pending <= 1'b1;
		polls = 0;
		repeat (1000) begin
			@(negedge clk);
			polls += pollRequest;
		end
		chkBit(polls >= 9 && polls <= 11, 1'b1);
		pending <= 1'b0;
		apb(1'b1, `EDSC_OFF_MODE, 32'h4);
		waitSleep(1'b1, 300);
		@(posedge clk);
		reqLevel <= 1'b1;
		repeat (3) @(posedge clk);
		reqLevel <= 1'b0;
		repeat (10) @(negedge clk);
		chkBit(sleeping, 1'b1);
		waitSleep(1'b0, 400);
		pulse(0);
		chkBit(sleeping, 1'b0);
		pulse(0);
		chkBit(sleeping, 1'b0);
		waitSleep(1'b1, 60);
		waitSleep(1'b0, 400);
		apb(1'b1, `EDSC_OFF_HOLD, 32'h64);
		pulse(0);
		chkBit(sleeping, 1'b0);
		apb(1'b1, `EDSC_OFF_CTRL, 32'h1);
		waitSleep(1'b1, 12);
		apb(1'b1, `EDSC_OFF_MODE, 32'h5);
		apb(1'b1, `EDSC_OFF_OPTIONS, 32'h4);
		flowControlPinConfig <= 1'b0;
		polls = 0;
		waitSleep(1'b0, 400);
		repeat (40) begin
			@(negedge clk);
			polls += pollRequest;
		end
		chkBit(sleeping && polls == 1, 1'b1);
		chkBit(ctsN, 1'b0);
		@(posedge clk);
		reqLevel <= 1'b1;
		repeat (3) @(posedge clk);
		reqLevel <= 1'b0;
		waitSleep(1'b0, 10);
		complete_run;
	end
endmodule
bind edsc_sleep_ctrl edsc_sleep_monitor #(.TICK_CYCLES(TICK_CYCLES),
	.POLL_TICKS(POLL_TICKS)) mon_u (.clk(clk), .resetn(resetn),
	.flowControlPinConfig(flowControlPinConfig), .awakeIndicator(awakeIndicator),
	.ctsN(ctsN), .joined(joined), .txBusy(txBusy), .pollAck(pollAck),
	.ackPending(ackPending), .rxDone(rxDone), .pollRequest(pollRequest),
	.rxEnable(rxEnable), .scanStart(scanStart), .sleeping(sleeping));
`default_nettype wire
